// ### shared/metering_params.svh
// Constants for the metering accumulator and energy pulse generator.
`ifndef METERING_PARAMS_SVH
`define METERING_PARAMS_SVH

`define MT_SAMPLE_W 24
`define MT_ACC_W 48
`define MT_FIFO_DEPTH 8
`define MT_PRELOAD_W 8
`define MT_PRELOAD_BASE 8'h80
`define MT_SAMPLE_RATE 4096
`define MT_FRAME_SAMPLES 16'h1000
`define MT_POWER_UNITS_PER_W 100
`define MT_SECONDS_PER_HOUR 3600
`define MT_ONE_KWH_ACC 48'h15752A00000
`define MT_PULSES_PER_KWH 48'h1900
`define MT_PULSE_THRESH (`MT_ONE_KWH_ACC / `MT_PULSES_PER_KWH)
`define MT_DC_FRAC 8
`define MT_DC_SHIFT 6
`define MT_PER_FRAC 8
`define MT_PER_SHIFT 3
`define MT_PER_INIT 24'h0051EC
`define MT_MAX_SLEW 25'h0200000
`define MT_HIST_DEPTH 32
`define MT_HIST_AW 5
`define MT_DIV_LAST 3'h7
`define MT_PERIOD_W 24

`endif

// ### shared/metering_pkg.sv
// Types shared by the metering accumulator design.
`include "metering_params.svh"

package metering_pkg;

    typedef logic signed [`MT_SAMPLE_W-1:0] sample_t;
    typedef logic [`MT_ACC_W-1:0] acc_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CORR = 5'h02,
        ST_ACC  = 5'h04,
        ST_DIV  = 5'h08,
        ST_CYC  = 5'h10
    } mt_state_e;

endpackage

// ### hw/metering_accumulator_pulse_gen.sv
// Metrology back end: sample FIFO, offset removal, accumulation, cycle tracking, energy pulses.
// Operation
// - Each sample event takes three samples and adds results into 48-bit accumulators.
// - After about one second of samples a frame-ready indication is raised.
// - Samples are signed; each channel subtracts its own dc tracking estimate.
// - The dc tracking filters update only at mains cycle boundaries.
// - Squares of corrected voltage and currents go into sum-of-squares accumulators.
// - Voltage times current products go into the active accumulator.
// - Current times quarter-cycle delayed voltage goes into the reactive accumulator.
// - Each converter has its own sample delay preload, loaded with a calibrated value.
// - Larger phase correction adds a whole-sample delay to the fractional delay.
// - Phase compensation may change at any time without stopping accumulation.
// - A mains cycle counter and a frame sample counter are kept.
// - Frames close only at cycle boundaries, latching totals and sample count.
// - Zero crossings are located by linear interpolation between bracketing samples.
// - A rate-of-change check rejects implausible sign changes as crossings.
// - The cycle period passes a weak low-pass filter for the frequency report.
// - Each sample event adds average power to an energy accumulator; crossing emits pulse.
// - On a pulse the threshold is subtracted and the excess kept.
// - Pulse rate is 6400 per kWh, separately for active and reactive.
// - Each pulse drives an output pin with per-pulse width, then returns idle.
// - Power is in 0.01 W; one kWh equals 0x15752A00000 at 4096 events.
// - Voltage on the first converter, line current second, neutral current third.
`timescale 1ns/10ps
`default_nettype none
`include "metering_params.svh"

// ==========================================================================
// Sample FIFO
module sample_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,               // System clock.
    input wire logic rst_b_i,             // Asynchronous reset, active low.
    input wire logic in_valid_i,          // Word offered.
    output logic in_ready_o,              // Space available.
    input wire logic [WIDTH-1:0] in_data_i, // Word in.
    output logic out_valid_o,             // Word available.
    input wire logic out_ready_i,         // Drain side takes word.
    output logic [WIDTH-1:0] out_data_o   // Word out.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, ready_d, valid_q, valid_d;
    logic push, pop;

    assign in_ready_o = ready_q;
    assign out_valid_o = valid_q;
    assign out_data_o = mem[rd_q];

    always_comb begin
        push = in_valid_i && ready_q;
        pop = valid_q && out_ready_i;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
        ready_d = (cnt_d != (AW+1)'(DEPTH));
        valid_d = (cnt_d != '0);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            valid_q <= valid_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end
endmodule

// ==========================================================================
// Metering accumulator and pulse generator
module metering_accumulator_pulse_gen
    import metering_pkg::*;
(
    input wire logic clk_i,                            // System clock, 20 MHz.
    input wire logic rst_b_i,                          // Asynchronous reset, active low.
    input wire logic sample_valid_i,                   // Converter sample event.
    input wire logic [`MT_SAMPLE_W-1:0] voltage_sample_i, // First converter result.
    input wire logic [`MT_SAMPLE_W-1:0] line_current_sample_i, // Second converter.
    input wire logic [`MT_SAMPLE_W-1:0] neutral_current_sample_i, // Third converter.
    output logic sample_ready_o,                       // FIFO has room.
    input wire logic [`MT_PRELOAD_W-1:0] preload_voltage_i, // Calibrated preload, voltage.
    input wire logic [`MT_PRELOAD_W-1:0] preload_line_i,    // Calibrated preload, line.
    input wire logic [`MT_PRELOAD_W-1:0] preload_neutral_i, // Calibrated preload, neutral.
    input wire logic [1:0] whole_delay_i,              // Whole-sample voltage delay.
    output logic [`MT_PRELOAD_W-1:0] sample_delay_preload_v_o, // To voltage converter.
    output logic [`MT_PRELOAD_W-1:0] sample_delay_preload_l_o, // To line converter.
    output logic [`MT_PRELOAD_W-1:0] sample_delay_preload_n_o, // To neutral converter.
    input wire logic frame_ack_i,                      // Averaging stage took frame.
    output logic frame_ready_o,                        // Frame totals valid.
    output logic [`MT_ACC_W-1:0] frame_v_sq_o,         // Voltage sum of squares.
    output logic [`MT_ACC_W-1:0] frame_il_sq_o,        // Line current sum of squares.
    output logic [`MT_ACC_W-1:0] frame_in_sq_o,        // Neutral current sum of squares.
    output logic [`MT_ACC_W-1:0] frame_active_o,       // Active product sum.
    output logic [`MT_ACC_W-1:0] frame_reactive_o,     // Reactive product sum.
    output logic [15:0] frame_samples_o,               // Samples in frame.
    output logic [7:0] frame_cycles_o,                 // Mains cycles in frame.
    output logic [`MT_PERIOD_W-1:0] mains_period_o,    // Filtered period, 1/256 sample.
    input wire logic [31:0] active_power_i,            // Average active power, 0.01 W.
    input wire logic [31:0] reactive_power_i,          // Average reactive power, 0.01 var.
    input wire logic [7:0] pulse_width_i,              // Pulse width in sample events.
    output logic active_pulse_o,                       // Active energy pulse pin.
    output logic reactive_pulse_o                      // Reactive energy pulse pin.
);
    localparam int FW = 3 * `MT_SAMPLE_W;

    // ======================================================================
    // Sample buffering
    logic fifo_valid, fifo_pop;
    logic [FW-1:0] fifo_data;

    sample_fifo #(
        .WIDTH(FW),
        .DEPTH(`MT_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .in_data_i({neutral_current_sample_i, line_current_sample_i, voltage_sample_i}),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // ======================================================================
    // Processing state
    mt_state_e state_q, state_d;
    sample_t smp_q [3], smp_d [3];
    sample_t corr_q [3], corr_d [3];
    logic signed [31:0] dc_q [3], dc_d [3];
    logic signed [31:0] res_q [3], res_d [3];
    sample_t prev_v_q, prev_v_d;
    logic [`MT_HIST_AW-1:0] wr_ptr_q, wr_ptr_d, idx_a, idx_r, qdel;
    acc_t acc_sq_q [3], acc_sq_d [3];
    acc_t acc_act_q, acc_act_d, acc_rea_q, acc_rea_d;
    logic [15:0] scnt_q, scnt_d, since_q, since_d;
    logic [7:0] ccnt_q, ccnt_d, last_frac_q, last_frac_d, quo_q, quo_d;
    logic cross_q, cross_d;
    logic [2:0] div_cnt_q, div_cnt_d;
    logic [`MT_SAMPLE_W:0] rem_q, rem_d, den_q, den_d, rem2, slew;
    logic [`MT_PERIOD_W-1:0] per_q, per_d, period;
    logic signed [`MT_PERIOD_W-1:0] per_step;
    acc_t f_sq_q [3], f_sq_d [3];
    acc_t f_act_q, f_act_d, f_rea_q, f_rea_d;
    logic [15:0] f_smp_q, f_smp_d;
    logic [7:0] f_cyc_q, f_cyc_d;
    logic f_rdy_q, f_rdy_d, frame_set;
    logic [`MT_PRELOAD_W-1:0] pre_q [3], pre_d [3];
    sample_t vhist [`MT_HIST_DEPTH];
    sample_t v_act, v_rea;
    logic sample_tick;

    // Reactive delay is a quarter of the filtered period in whole samples.
    assign qdel = per_q[`MT_PER_FRAC+6:`MT_PER_FRAC+2];
    assign idx_a = wr_ptr_q - `MT_HIST_AW'(whole_delay_i);
    assign idx_r = idx_a - qdel;
    assign v_act = vhist[idx_a];
    assign v_rea = vhist[idx_r];
    assign fifo_pop = (state_q == ST_IDLE);
    assign sample_tick = (state_q == ST_ACC);

    always_comb begin
        state_d = state_q;
        smp_d = smp_q;
        corr_d = corr_q;
        dc_d = dc_q;
        res_d = res_q;
        prev_v_d = prev_v_q;
        wr_ptr_d = wr_ptr_q;
        acc_sq_d = acc_sq_q;
        acc_act_d = acc_act_q;
        acc_rea_d = acc_rea_q;
        scnt_d = scnt_q;
        since_d = since_q;
        ccnt_d = ccnt_q;
        last_frac_d = last_frac_q;
        quo_d = quo_q;
        cross_d = cross_q;
        div_cnt_d = div_cnt_q;
        rem_d = rem_q;
        den_d = den_q;
        per_d = per_q;
        f_sq_d = f_sq_q;
        f_act_d = f_act_q;
        f_rea_d = f_rea_q;
        f_smp_d = f_smp_q;
        f_cyc_d = f_cyc_q;
        frame_set = 1'b0;
        rem2 = {rem_q[`MT_SAMPLE_W-1:0], 1'b0};
        slew = '0;
        period = `MT_PERIOD_W'({since_q, last_frac_q} - quo_q);
        per_step = $signed(period - per_q) >>> `MT_PER_SHIFT;
        // Preloads follow the calibration inputs at all times.
        pre_d[0] = preload_voltage_i;
        pre_d[1] = preload_line_i;
        pre_d[2] = preload_neutral_i;
        case (state_q)
            ST_IDLE: begin
                if (fifo_valid) begin
                    for (int ch = 0; ch < 3; ch++) begin
                        // Lane 0 voltage, lane 1 line current, lane 2 neutral.
                        smp_d[ch] = fifo_data[ch*`MT_SAMPLE_W +: `MT_SAMPLE_W];
                    end
                    state_d = ST_CORR;
                end
            end
            ST_CORR: begin
                for (int ch = 0; ch < 3; ch++) begin
                    corr_d[ch] = smp_q[ch] - sample_t'(dc_q[ch] >>> `MT_DC_FRAC);
                    res_d[ch] = res_q[ch] + 32'(corr_d[ch]);
                end
                slew = (`MT_SAMPLE_W+1)'(corr_d[0]) - (`MT_SAMPLE_W+1)'(prev_v_q);
                cross_d = 1'b0;
                if (prev_v_q < 0 && corr_d[0] >= 0 && slew <= `MT_MAX_SLEW) begin
                    cross_d = 1'b1;
                    rem_d = (`MT_SAMPLE_W+1)'(corr_d[0]);
                    den_d = slew;
                    quo_d = '0;
                    div_cnt_d = '0;
                end
                prev_v_d = corr_d[0];
                state_d = ST_ACC;
            end
            ST_ACC: begin
                for (int ch = 0; ch < 3; ch++) begin
                    acc_sq_d[ch] = acc_sq_q[ch] + acc_t'(corr_q[ch] * corr_q[ch]);
                end
                acc_act_d = acc_act_q + acc_t'(v_act * corr_q[1]);
                acc_rea_d = acc_rea_q + acc_t'(v_rea * corr_q[1]);
                wr_ptr_d = wr_ptr_q + 1'b1;
                scnt_d = scnt_q + 1'b1;
                since_d = since_q + 1'b1;
                state_d = cross_q ? ST_DIV : ST_IDLE;
            end
            ST_DIV: begin
                // Restoring division gives the crossing position between the samples.
                if (rem2 >= den_q) begin
                    rem_d = rem2 - den_q;
                    quo_d = {quo_q[6:0], 1'b1};
                end else begin
                    rem_d = rem2;
                    quo_d = {quo_q[6:0], 1'b0};
                end
                div_cnt_d = div_cnt_q + 1'b1;
                if (div_cnt_q == `MT_DIV_LAST) begin
                    state_d = ST_CYC;
                end
            end
            ST_CYC: begin
                per_d = per_q + `MT_PERIOD_W'(per_step);
                last_frac_d = quo_q;
                since_d = '0;
                cross_d = 1'b0;
                ccnt_d = ccnt_q + 1'b1;
                for (int ch = 0; ch < 3; ch++) begin
                    dc_d[ch] = dc_q[ch] + (res_q[ch] >>> `MT_DC_SHIFT);
                    res_d[ch] = '0;
                end
                if (scnt_q >= `MT_FRAME_SAMPLES) begin
                    f_sq_d = acc_sq_q;
                    f_act_d = acc_act_q;
                    f_rea_d = acc_rea_q;
                    f_smp_d = scnt_q;
                    f_cyc_d = ccnt_q + 1'b1;
                    frame_set = 1'b1;
                    for (int ch = 0; ch < 3; ch++) begin
                        acc_sq_d[ch] = '0;
                    end
                    acc_act_d = '0;
                    acc_rea_d = '0;
                    scnt_d = '0;
                    ccnt_d = '0;
                end
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A new frame wins over an acknowledge in the same cycle.
        f_rdy_d = (f_rdy_q && !frame_ack_i) || frame_set;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            for (int ch = 0; ch < 3; ch++) begin
                smp_q[ch] <= '0;
                corr_q[ch] <= '0;
                dc_q[ch] <= '0;
                res_q[ch] <= '0;
                acc_sq_q[ch] <= '0;
                f_sq_q[ch] <= '0;
                pre_q[ch] <= `MT_PRELOAD_BASE;
            end
            prev_v_q <= '0;
            wr_ptr_q <= '0;
            acc_act_q <= '0;
            acc_rea_q <= '0;
            scnt_q <= '0;
            since_q <= '0;
            ccnt_q <= '0;
            last_frac_q <= '0;
            quo_q <= '0;
            cross_q <= 1'b0;
            div_cnt_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            per_q <= `MT_PER_INIT;
            f_act_q <= '0;
            f_rea_q <= '0;
            f_smp_q <= '0;
            f_cyc_q <= '0;
            f_rdy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            smp_q <= smp_d;
            corr_q <= corr_d;
            dc_q <= dc_d;
            res_q <= res_d;
            acc_sq_q <= acc_sq_d;
            f_sq_q <= f_sq_d;
            pre_q <= pre_d;
            prev_v_q <= prev_v_d;
            wr_ptr_q <= wr_ptr_d;
            acc_act_q <= acc_act_d;
            acc_rea_q <= acc_rea_d;
            scnt_q <= scnt_d;
            since_q <= since_d;
            ccnt_q <= ccnt_d;
            last_frac_q <= last_frac_d;
            quo_q <= quo_d;
            cross_q <= cross_d;
            div_cnt_q <= div_cnt_d;
            rem_q <= rem_d;
            den_q <= den_d;
            per_q <= per_d;
            f_act_q <= f_act_d;
            f_rea_q <= f_rea_d;
            f_smp_q <= f_smp_d;
            f_cyc_q <= f_cyc_d;
            f_rdy_q <= f_rdy_d;
        end
    end

    // Voltage history for whole-sample and quarter-cycle delays.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vhist <= '{default: '0};
        end else if (state_q == ST_CORR) begin
            vhist[wr_ptr_q] <= corr_d[0];
        end
    end

    assign sample_delay_preload_v_o = pre_q[0];
    assign sample_delay_preload_l_o = pre_q[1];
    assign sample_delay_preload_n_o = pre_q[2];
    assign frame_ready_o = f_rdy_q;
    assign frame_v_sq_o = f_sq_q[0];
    assign frame_il_sq_o = f_sq_q[1];
    assign frame_in_sq_o = f_sq_q[2];
    assign frame_active_o = f_act_q;
    assign frame_reactive_o = f_rea_q;
    assign frame_samples_o = f_smp_q;
    assign frame_cycles_o = f_cyc_q;
    assign mains_period_o = per_q;

    // ======================================================================
    // Energy pulse generation, active and reactive
    logic [31:0] power [2];
    logic pin [2];

    assign power[0] = active_power_i;
    assign power[1] = reactive_power_i;
    assign active_pulse_o = pin[0];
    assign reactive_pulse_o = pin[1];

    for (genvar k = 0; k < 2; k++) begin : g_pulse
        acc_t eacc_q, eacc_d, esum;
        logic [7:0] wcnt_q, wcnt_d;
        logic pin_q, pin_d;

        always_comb begin
            eacc_d = eacc_q;
            wcnt_d = wcnt_q;
            pin_d = pin_q;
            esum = eacc_q + acc_t'(power[k]);
            if (sample_tick) begin
                eacc_d = esum;
                if (wcnt_q != 8'h00) begin
                    wcnt_d = wcnt_q - 1'b1;
                end
                if (wcnt_d == 8'h00) begin
                    pin_d = 1'b0;
                end
                if (esum >= acc_t'(`MT_PULSE_THRESH)) begin
                    eacc_d = esum - acc_t'(`MT_PULSE_THRESH);
                    wcnt_d = (pulse_width_i == 8'h00) ? 8'h01 : pulse_width_i;
                    pin_d = 1'b1;
                end
            end
        end

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                eacc_q <= '0;
                wcnt_q <= '0;
                pin_q <= 1'b0;
            end else begin
                eacc_q <= eacc_d;
                wcnt_q <= wcnt_d;
                pin_q <= pin_d;
            end
        end

        assign pin[k] = pin_q;
    end
endmodule

`default_nettype wire

// ### tb/sample_source.sv
// Converter model: three samples per event, held until taken.
`timescale 1ns/10ps
`default_nettype none
module sample_source (
    input wire logic clk_i, // System clock.
    input wire logic rst_b_i, // Reset, active low.
    input wire logic run_i, // Produce sample events.
    input wire logic burst_i, // No gap between events.
    input wire logic wave_i, // Triangle instead of zero.
    input wire logic ready_i, // Block takes the word.
    output logic valid_o, // Sample event.
    output logic [23:0] volt_o, // First converter.
    output logic [23:0] line_o, // Second converter.
    output logic [23:0] neut_o // Third converter.
);
    logic [6:0] ph_q;
    logic [2:0] gap_q;
    logic signed [23:0] v;
    int k;
    // ==========
    // Triangle of 80 samples; unqualified lines show the inverse.
    always_comb begin
        k = (ph_q < 7'h28) ? int'(ph_q) - 32'sh14 : 32'sh3C - int'(ph_q);
        v = wave_i ? 24'(k <<< 12) : 24'h0;
    end
    assign volt_o = valid_o ? v : ~v;
    assign line_o = valid_o ? v >>> 1 : ~v;
    assign neut_o = valid_o ? v >>> 2 : ~v;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_o <= 1'b0;
            gap_q <= 3'h7;
            ph_q <= 7'h0;
        end else if (valid_o) begin
            if (ready_i) begin
                valid_o <= burst_i & run_i;
                gap_q <= 3'h7;
                ph_q <= (ph_q == 7'h4F) ? 7'h0 : ph_q + 7'h1;
            end
        end else if (gap_q != 3'h0) begin
            gap_q <= gap_q - 3'h1;
        end else begin
            valid_o <= run_i;
        end
    end
endmodule
`default_nettype wire

// ### tb/metering_chk.sv
// Port assertions for the metering block.
`timescale 1ns/10ps
`default_nettype none
`include "metering_params.svh"
module metering_chk (
    input wire logic clk_i, // Clock.
    input wire logic rst_b_i, // Reset, active low.
    input wire logic sample_valid_i, // Sample event.
    input wire logic sample_ready_o, // FIFO room.
    input wire logic [`MT_PRELOAD_W-1:0] preload_voltage_i, // Preload in.
    input wire logic [`MT_PRELOAD_W-1:0] preload_line_i, // Preload in.
    input wire logic [`MT_PRELOAD_W-1:0] preload_neutral_i, // Preload in.
    input wire logic [`MT_PRELOAD_W-1:0] sample_delay_preload_v_o, // Preload out.
    input wire logic [`MT_PRELOAD_W-1:0] sample_delay_preload_l_o, // Preload out.
    input wire logic [`MT_PRELOAD_W-1:0] sample_delay_preload_n_o, // Preload out.
    input wire logic frame_ack_i, // Frame taken.
    input wire logic frame_ready_o, // Frame valid.
    input wire logic [`MT_ACC_W-1:0] frame_active_o, // Active sum.
    input wire logic [15:0] frame_samples_o, // Sample count.
    input wire logic [7:0] frame_cycles_o, // Cycle count.
    input wire logic active_pulse_o, // Active pin.
    input wire logic reactive_pulse_o // Reactive pin.
);
    // ==========
    // Port relations.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    preload_follow_a: assert property (rst_b_i |=> sample_delay_preload_v_o ==
        $past(preload_voltage_i) && sample_delay_preload_l_o == $past(preload_line_i) &&
        sample_delay_preload_n_o == $past(preload_neutral_i)) else $error("preload not followed");
    ack_clear_a: assert property (frame_ready_o && frame_ack_i |=>
        !frame_ready_o || !$stable(frame_samples_o)) else $error("ack did not clear frame");
    ready_hold_a: assert property (frame_ready_o && !frame_ack_i |=> frame_ready_o)
        else $error("ready lost without ack");
    frame_len_a: assert property ($rose(frame_ready_o) |-> frame_samples_o >= 16'h1000)
        else $error("frame closed too early");
    frame_cyc_a: assert property ($rose(frame_ready_o) |-> frame_cycles_o != 8'h0)
        else $error("frame has no cycle");
    totals_latch_a: assert property (
        !$stable(frame_active_o) || !$stable(frame_samples_o) |-> frame_ready_o)
        else $error("totals moved without ready");
    act_width_a: assert property ($rose(active_pulse_o) |-> active_pulse_o [*3])
        else $error("active pulse too short");
    rea_width_a: assert property ($rose(reactive_pulse_o) |-> reactive_pulse_o [*3])
        else $error("reactive pulse too short");
    fifo_full_a: assert property ($fell(sample_ready_o) |-> $past(sample_valid_i))
        else $error("full without a push");
endmodule
bind metering_accumulator_pulse_gen metering_chk chk (.clk_i, .rst_b_i, .sample_valid_i,
    .sample_ready_o, .preload_voltage_i, .preload_line_i, .preload_neutral_i,
    .sample_delay_preload_v_o, .sample_delay_preload_l_o, .sample_delay_preload_n_o,
    .frame_ack_i, .frame_ready_o, .frame_active_o, .frame_samples_o, .frame_cycles_o,
    .active_pulse_o, .reactive_pulse_o);
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the metering block.
`timescale 1ns/10ps
`default_nettype none
`include "metering_params.svh"
module tb;
    typedef struct {
        logic [31:0] pa, pr;
        logic [7:0] w, pv, pl, pn;
        int n, ea, er;
    } row_s;
    row_s rows[3] = '{
        '{32'h036EE800, 32'h0493E000, 8'h02, 8'h80, 8'h80, 8'h80, 24, 6, 8},
        '{32'h036EE7FF, 32'h00000000, 8'h02, 8'hFF, 8'h00, 8'h81, 24, 5, 0},
        '{32'h00000000, 32'h06DDD000, 8'h00, 8'h7F, 8'h90, 8'h80, 12, 0, 6}};
    logic clk_i = 1'b0, rst_b_i = 1'b1, run, burst, wave, valid, ready, ack, fr, ap, rp;
    logic ap_q = 1'b0, rp_q = 1'b0;
    logic [1:0] wd;
    logic [7:0] pv, pl, pn, dpv, dpl, dpn, w, fcyc;
    logic [15:0] fsamp;
    logic [23:0] sv, sl, sn, per;
    logic [31:0] pa, pr;
    logic [`MT_ACC_W-1:0] frv, fil, fin, fact, frea;
    int n_mismatch = 0, n_tests = 0, n_taken = 0, n_ap = 0, n_rp = 0, a0, r0;
    always #25 clk_i = ~clk_i;
    sample_source src (.clk_i(clk_i), .rst_b_i(rst_b_i), .run_i(run), .burst_i(burst),
        .wave_i(wave), .ready_i(ready), .valid_o(valid), .volt_o(sv), .line_o(sl), .neut_o(sn));
    metering_accumulator_pulse_gen uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .sample_valid_i(valid), .voltage_sample_i(sv), .line_current_sample_i(sl),
        .neutral_current_sample_i(sn), .sample_ready_o(ready), .preload_voltage_i(pv),
        .preload_line_i(pl), .preload_neutral_i(pn), .whole_delay_i(wd),
        .sample_delay_preload_v_o(dpv), .sample_delay_preload_l_o(dpl),
        .sample_delay_preload_n_o(dpn), .frame_ack_i(ack), .frame_ready_o(fr),
        .frame_v_sq_o(frv), .frame_il_sq_o(fil), .frame_in_sq_o(fin), .frame_active_o(fact),
        .frame_reactive_o(frea), .frame_samples_o(fsamp), .frame_cycles_o(fcyc),
        .mains_period_o(per), .active_power_i(pa), .reactive_power_i(pr), .pulse_width_i(w),
        .active_pulse_o(ap), .reactive_pulse_o(rp));
    // ==========
    // Event counters, sampled at the falling edge.
    always @(negedge clk_i) begin
        n_taken <= n_taken + int'(valid && ready);
        n_ap <= n_ap + int'(ap && !ap_q);
        n_rp <= n_rp + int'(rp && !rp_q);
        ap_q <= ap;
        rp_q <= rp;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset();
        run <= 1'b0;
        rst_b_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check({dpv, dpl, dpn}, 24'h808080);
        check(per, 24'h0051EC);
        check({fr, ap, rp, ready}, 4'h0);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic feed(input int n);
        int base;
        base = n_taken;
        run <= 1'b1;
        for (int i = 0; i < 2000 && n_taken < base + n; i++) @(posedge clk_i);
        run <= 1'b0;
        repeat (60) @(posedge clk_i);
    endtask
    initial begin
        repeat (50000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end
    // ==========
    // Pulse table, then fifo fill, frame close and ack.
    initial begin
        {burst, wave, ack, wd, pa, pr, w} <= '0;
        {pv, pl, pn} <= 24'h808080;
        foreach (rows[i]) begin
            do_reset();
            {pa, pr, w} <= {rows[i].pa, rows[i].pr, rows[i].w};
            {pv, pl, pn} <= {rows[i].pv, rows[i].pl, rows[i].pn};
            a0 = n_ap;
            r0 = n_rp;
            feed(rows[i].n);
            check(32'(n_ap - a0), 32'(rows[i].ea));
            check(32'(n_rp - r0), 32'(rows[i].er));
            check({dpv, dpl, dpn}, {rows[i].pv, rows[i].pl, rows[i].pn});
        end
        do_reset();
        burst <= 1'b1;
        run <= 1'b1;
        for (int i = 0; i < 200 && ready !== 1'b0; i++) @(negedge clk_i);
        check(ready, 1'b0);
        @(posedge clk_i);
        run <= 1'b0;
        for (int i = 0; i < 200 && ready !== 1'b1; i++) @(negedge clk_i);
        check(ready, 1'b1);
        @(posedge clk_i);
        burst <= 1'b0;
        do_reset();
        {wave, wd, pa} <= {1'b1, 2'h1, 32'h036EE800};
        run <= 1'b1;
        repeat (3000) @(posedge clk_i);
        pv <= 8'h90;
        for (int i = 0; i < 60000 && fr !== 1'b1; i++) @(negedge clk_i);
        check(fsamp >= 16'h1000 && fsamp <= 16'h1050, 1'b1);
        check(fcyc >= 8'h32 && fcyc <= 8'h35, 1'b1);
        check(per >= 24'h4F80 && per <= 24'h5080, 1'b1);
        check(frv != 48'h0 && fil != 48'h0 && fin != 48'h0 && fact[47] == 1'b0, 1'b1);
        check(frea + (fact >> 2) < (fact >> 1), 1'b1);
        check(dpv, 8'h90);
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
        @(negedge clk_i);
        check(fr, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
